// ==== core/emf_pkg.sv ====
package emf_pkg;
	// Register byte addresses, one 32-bit word each
	localparam logic [31:0] MAC_GLOBAL_CONTROL_A = 32'hf00b0000;
	localparam logic [31:0] ADDRESS_FILTER_CONTROL_A = 32'hf00b0004;
	localparam logic [31:0] MAC_GLOBAL_CONTROL_B = 32'hf00d0000;
	localparam logic [31:0] ADDRESS_FILTER_CONTROL_B = 32'hf00d0004;
	localparam int NCH = 2;

	// Control register fields
	localparam int CB_HALT_REQ = 0;
	localparam int CB_STOP_NOW = 1;
	localparam int CB_SOFT_RST = 2;
	localparam int CB_FULL_DUP = 3;
	localparam int CB_WRAP = 4;
	localparam int CB_ENDEC_SEL = 6;
	localparam int CB_LOOP_OUT = 7;
	localparam int CB_MDC_GATE = 12;
	localparam int CB_LINK_IN = 15;
	// Writable control bits; reset and link bits are handled apart
	localparam logic [15:0] CTRL_WMASK = 16'h10db;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Filter register fields
	localparam int FB_UNI = 0;
	localparam int FB_MULTI = 1;
	localparam int FB_BCAST = 2;
	localparam int FB_INVERT = 3;
	localparam int FB_MATCH_ON = 4;
	localparam logic [4:0] FILT_RESET = 5'h00;

	// Destination address layout: first byte sits in the top bits
	localparam int ADDR_W = 48;
	localparam int GROUP_BIT = 40;
	localparam logic [47:0] BCAST_ADDR = 48'hffffffffffff;

	// Timing
	localparam longint CLK_HZ = 125_000_000;
	localparam longint MDC_MAX_HZ = 2_500_000;
	localparam int MDC_HALF = int'((CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ));
	localparam logic [7:0] MDC_HALF_CNT = 8'(MDC_HALF - 1);
	localparam logic [3:0] SRST_CYCLES = 4'h4;

	typedef enum logic [1:0] {CLS_UNI, CLS_MULTI, CLS_BCAST} emf_class_type;
	typedef enum logic {SR_IDLE, SR_BUSY} emf_srst_type;
endpackage

// ==== core/emf_top.sv ====
`timescale 1ns/10ps
module emf_top
	import emf_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] tx_busy,
	input wire logic [1:0] rx_busy,
	input wire logic [1:0] link10_pin,
	input wire logic [1:0] rx_addr_valid,
	input wire logic [1:0][47:0] rx_dest_addr,
	input wire logic [1:0] cam_hit,
	output logic [1:0] tx_run,
	output logic [1:0] rx_run,
	output logic [1:0] tx_start_ok,
	output logic [1:0] wrap_on,
	output logic [1:0] tx_pins_en,
	output logic [1:0] endec_sel,
	output logic [1:0] endec_loop_signal,
	output logic [1:0] mdc,
	output logic [1:0] mac_sm_reset,
	output logic [1:0] rx_accept,
	output logic [1:0] rx_accept_valid
);
	import emf_pkg::*;

	// Classify a destination address
	function automatic emf_class_type addr_class(input logic [47:0] a);
		if (a == BCAST_ADDR) begin
			return CLS_BCAST;
		end else if (a[GROUP_BIT]) begin
			return CLS_MULTI;
		end else begin
			return CLS_UNI;
		end
	endfunction

	// Apply 16-bit control write with byte lanes
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	logic req;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [1:0][15:0] ctrl_q;
	logic [1:0][4:0] filt_q;
	logic [1:0] link_q;
	logic [1:0] rst_busy;
	logic [1:0] hit_ctrl;
	logic [1:0] hit_filt;
	logic [31:0] rd_mux;

	assign req = avs_read | avs_write;
	assign hit_ctrl[0] = (avs_address == MAC_GLOBAL_CONTROL_A);
	assign hit_ctrl[1] = (avs_address == MAC_GLOBAL_CONTROL_B);
	assign hit_filt[0] = (avs_address == ADDRESS_FILTER_CONTROL_A);
	assign hit_filt[1] = (avs_address == ADDRESS_FILTER_CONTROL_B);

	// Every access waits one cycle so read data can come from a flop
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wait_q <= 1'b1;
		end else if (req && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h00000000;
		for (int i = 0; i < NCH; i++) begin
			if (hit_ctrl[i]) begin
				rd_mux[15:0] = ctrl_q[i] & CTRL_WMASK;
				rd_mux[CB_SOFT_RST] = rst_busy[i];
				rd_mux[CB_LINK_IN] = link_q[i];
			end
			if (hit_filt[i]) begin
				rd_mux[4:0] = filt_q[i];
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (avs_read && wait_q) begin
			rdata_q <= rd_mux;
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_ch
			logic wr_ctrl;
			logic wr_filt;
			logic soft_go;
			emf_srst_type sr_q;
			logic [3:0] sr_cnt_q;
			logic tx_run_q;
			logic rx_run_q;
			logic start_q;
			logic [7:0] mdc_cnt_q;
			logic mdc_q;
			logic acc_q;
			logic accv_q;
			logic smr_q;
			logic [4:0] f;
			logic duplex_eff;
			logic class_ok;
			logic cam_ok;
			emf_class_type cls;

			// Writes take effect at the edge where waitrequest is low
			assign wr_ctrl = avs_write && !wait_q && hit_ctrl[g];
			assign wr_filt = avs_write && !wait_q && hit_filt[g];
			assign soft_go = wr_ctrl && avs_byteenable[0] && avs_writedata[CB_SOFT_RST];
			assign rst_busy[g] = (sr_q == SR_BUSY);

			// Soft reset sequencer; bit reads one until it finishes
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					sr_q <= SR_IDLE;
					sr_cnt_q <= 4'h0;
					smr_q <= 1'b0;
				end else begin
					case (sr_q)
						SR_IDLE: begin
							smr_q <= 1'b0;
							if (soft_go) begin
								sr_q <= SR_BUSY;
								sr_cnt_q <= SRST_CYCLES;
								smr_q <= 1'b1;
							end
						end
						SR_BUSY: begin
							if (sr_cnt_q == 4'h1) begin
								sr_q <= SR_IDLE;
								smr_q <= 1'b0;
							end
							sr_cnt_q <= sr_cnt_q - 4'h1;
						end
						default: begin
							sr_q <= SR_IDLE;
						end
					endcase
				end
			end

			// Control register; soft reset clears it, writes ignored meanwhile
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					ctrl_q[g] <= CTRL_RESET;
				end else if (soft_go || rst_busy[g]) begin
					ctrl_q[g] <= CTRL_RESET;
				end else if (wr_ctrl) begin
					ctrl_q[g] <= merge16(ctrl_q[g], avs_writedata, avs_byteenable) & CTRL_WMASK;
				end
			end

			// Filter register
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					filt_q[g] <= FILT_RESET;
				end else if (soft_go || rst_busy[g]) begin
					filt_q[g] <= FILT_RESET;
				end else if (wr_filt && avs_byteenable[0]) begin
					filt_q[g] <= avs_writedata[4:0];
				end
			end

			// One flop buffers the link pin
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					link_q[g] <= 1'b0;
				end else begin
					link_q[g] <= link10_pin[g];
				end
			end

			// Looped transmit is received at once, so wrap forces duplex
			assign duplex_eff = ctrl_q[g][CB_WRAP] | ctrl_q[g][CB_FULL_DUP];

			// Run state: stop-now cuts at once, halt waits for idle
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					tx_run_q <= 1'b1;
					rx_run_q <= 1'b1;
				end else if (ctrl_q[g][CB_STOP_NOW] || rst_busy[g]) begin
					tx_run_q <= 1'b0;
					rx_run_q <= 1'b0;
				end else if (ctrl_q[g][CB_HALT_REQ]) begin
					if (!tx_busy[g]) begin
						tx_run_q <= 1'b0;
					end
					if (!rx_busy[g]) begin
						rx_run_q <= 1'b0;
					end
				end else begin
					tx_run_q <= 1'b1;
					rx_run_q <= 1'b1;
				end
			end

			// No new frame may start while halting or, in half duplex, receiving
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					start_q <= 1'b0;
				end else begin
					start_q <= !ctrl_q[g][CB_STOP_NOW] && !ctrl_q[g][CB_HALT_REQ]
						&& !rst_busy[g] && (duplex_eff || !rx_busy[g]);
				end
			end

			// MDC divider; held low while gated to save power
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					mdc_cnt_q <= 8'h00;
					mdc_q <= 1'b0;
				end else if (ctrl_q[g][CB_MDC_GATE]) begin
					mdc_cnt_q <= 8'h00;
					mdc_q <= 1'b0;
				end else if (mdc_cnt_q == MDC_HALF_CNT) begin
					mdc_cnt_q <= 8'h00;
					mdc_q <= !mdc_q;
				end else begin
					mdc_cnt_q <= mdc_cnt_q + 8'h01;
				end
			end

			// Address filter decision
			assign f = filt_q[g];
			assign cls = addr_class(rx_dest_addr[g]);
			always_comb begin
				case (cls)
					CLS_UNI: class_ok = f[FB_UNI];
					CLS_MULTI: class_ok = f[FB_MULTI];
					CLS_BCAST: class_ok = f[FB_BCAST];
					default: class_ok = 1'b0;
				endcase
			end
			always_comb begin
				if (!f[FB_MATCH_ON]) begin
					cam_ok = 1'b1;
				end else if (f[FB_INVERT]) begin
					cam_ok = !cam_hit[g];
				end else begin
					cam_ok = cam_hit[g];
				end
			end

			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					acc_q <= 1'b0;
					accv_q <= 1'b0;
				end else begin
					accv_q <= rx_addr_valid[g];
					if (rx_addr_valid[g]) begin
						acc_q <= class_ok | cam_ok;
					end
				end
			end

			// Pin-facing outputs come straight from flops
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					wrap_on[g] <= 1'b0;
					tx_pins_en[g] <= 1'b1;
					endec_sel[g] <= 1'b0;
					endec_loop_signal[g] <= 1'b0;
				end else begin
					wrap_on[g] <= ctrl_q[g][CB_WRAP];
					tx_pins_en[g] <= !ctrl_q[g][CB_WRAP];
					endec_sel[g] <= ctrl_q[g][CB_ENDEC_SEL];
					endec_loop_signal[g] <= ctrl_q[g][CB_LOOP_OUT];
				end
			end

			assign tx_run[g] = tx_run_q;
			assign rx_run[g] = rx_run_q;
			assign tx_start_ok[g] = start_q;
			assign mdc[g] = mdc_q;
			assign mac_sm_reset[g] = smr_q;
			assign rx_accept[g] = acc_q;
			assign rx_accept_valid[g] = accv_q;
		end
	endgenerate
endmodule // emf_top

// ==== dv/emf_chk.sv ====
`timescale 1ns/10ps
module emf_chk
	import emf_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] link10_pin,
	input wire logic [1:0] rx_addr_valid,
	input wire logic [1:0] tx_start_ok,
	input wire logic [1:0] wrap_on,
	input wire logic [1:0] tx_pins_en,
	input wire logic [1:0] endec_sel,
	input wire logic [1:0] endec_loop_signal,
	input wire logic [1:0] mdc,
	input wire logic [1:0] mac_sm_reset,
	input wire logic [1:0] rx_accept_valid
);
	logic [7:0] mdc_cnt_q;
	logic wr_a;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Control write to channel A that does not start a soft reset
	assign wr_a = avs_write && !avs_waitrequest && avs_address == MAC_GLOBAL_CONTROL_A
		&& avs_byteenable[0] && !avs_writedata[2] && !mac_sm_reset[0];
	// Cycles since mdc last moved, saturating so long gating cannot wrap
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) mdc_cnt_q <= 8'h00;
		else if ($changed(mdc[0])) mdc_cnt_q <= 8'h00;
		else if (mdc_cnt_q != 8'hff) mdc_cnt_q <= mdc_cnt_q + 8'h01;
	end
	property p_loop; wr_a |=> ##1 endec_loop_signal[0] == $past(avs_writedata[7], 2); endproperty
	a_loop: assert property (p_loop) else $error("loop out mismatch");
	property p_sel; wr_a |=> ##1 endec_sel[0] == $past(avs_writedata[6], 2); endproperty
	a_sel: assert property (p_sel) else $error("endec select mismatch");
	property p_wrap;
		wr_a |=> ##1 wrap_on[0] == $past(avs_writedata[4], 2) && tx_pins_en[0] == !wrap_on[0];
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap or pin enable mismatch");
	property p_mdc; $rose(mdc[0]) |-> mdc_cnt_q >= 8'd24; endproperty
	a_mdc: assert property (p_mdc) else $error("mdc half period short");
	property p_srst; $rose(mac_sm_reset[0]) |-> mac_sm_reset[0] [*4] ##1 !mac_sm_reset[0]; endproperty
	a_srst: assert property (p_srst) else $error("soft reset length wrong");
	property p_srst_tx; mac_sm_reset[0] |=> !tx_start_ok[0]; endproperty
	a_srst_tx: assert property (p_srst_tx) else $error("tx start during soft reset");
	property p_acc; rx_addr_valid[0] |=> rx_accept_valid[0]; endproperty
	a_acc: assert property (p_acc) else $error("no filter decision");
	property p_acc_src; rx_accept_valid[0] |-> $past(rx_addr_valid[0]); endproperty
	a_acc_src: assert property (p_acc_src) else $error("decision without address");
	property p_link;
		avs_read && !avs_waitrequest && avs_address == MAC_GLOBAL_CONTROL_A |->
			avs_readdata[15] == $past(link10_pin[0], 2) && (avs_readdata & 32'hffff6f20) == 32'h0;
	endproperty
	a_link: assert property (p_link) else $error("control readback wrong");
endmodule // emf_chk
bind emf_top emf_chk chk_u (.*);

// ==== dv/emf_phy_model.sv ====
`timescale 1ns/10ps
// One receive frame per go pulse: busy 24 cycles, address seen once
module emf_phy_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [47:0] da,
	input wire logic hit,
	output logic rx_busy = 1'b0,
	output logic rx_addr_valid = 1'b0,
	output logic [47:0] rx_dest_addr = 48'h0,
	output logic cam_hit = 1'b0
);
	logic [4:0] n_q = 5'h0;
	// Address and hit toggle outside the pulse so a stale value never passes
	always_ff @(posedge mclk) begin
		if (go && n_q == 5'h0) n_q <= 5'h18;
		else if (n_q != 5'h0) n_q <= n_q - 5'h1;
		rx_busy <= go || n_q > 5'h1;
		rx_addr_valid <= n_q == 5'h17;
		rx_dest_addr <= (n_q == 5'h17) ? da : ~rx_dest_addr;
		cam_hit <= (n_q == 5'h17) ? hit : ~cam_hit;
	end
endmodule // emf_phy_model

// ==== dv/emf_top_tb.sv ====
`timescale 1ns/10ps
module emf_top_tb;
	import emf_pkg::*;
	localparam logic [8:0] T[12] = '{9'h004, 9'h00e, 9'h10c, 9'h100, 9'h188, 9'h185,
		9'h114, 9'h125, 9'h120, 9'h146, 9'h122, 9'h1ce};
	localparam logic [47:0] AD[3] = '{48'h00ffffffffff, 48'h010000000000, 48'hffffffffffff};
	logic mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata, rd_q;
	logic [3:0] avs_byteenable = 4'hf;
	logic [1:0] tx_busy = 2'h0, link10_pin = 2'h1, go = 2'h0, hit = 2'h0;
	logic [1:0] rx_busy, rx_addr_valid, cam_hit, tx_run, rx_run, tx_start_ok, wrap_on;
	logic [1:0] tx_pins_en, endec_sel, endec_loop_signal, mdc, mac_sm_reset, rx_accept;
	logic [1:0] rx_accept_valid;
	logic [1:0][47:0] da = 96'h0, rx_dest_addr;
	int errors = 0, cmp_count = 0, cyc = 0;
	emf_phy_model phy_u[1:0] (.mclk(mclk), .go(go), .da(da), .hit(hit), .rx_busy(rx_busy),
		.rx_addr_valid(rx_addr_valid), .rx_dest_addr(rx_dest_addr), .cam_hit(cam_hit));
	emf_top dut_u (.*);
	// Free-running system clock
	initial forever #4 mclk = ~mclk;
	// A hang is cut short here
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Extra edge after release so no signal is assigned twice in one step
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	function automatic logic [31:0] base(input int ch);
		return MAC_GLOBAL_CONTROL_A + 32'(ch) * 32'h20000;
	endfunction
	task automatic frame(input int ch, input logic [47:0] a, input logic h);
		da[ch] <= a;
		hit[ch] <= h;
		go[ch] <= 1'b1;
		@(posedge mclk);
		go[ch] <= 1'b0;
	endtask
	task automatic s_regs();
		for (int ch = 0; ch < 2; ch++) begin
			bus(0, base(ch) + 4, 0);
			chk(32'h0, rd_q);
			bus(1, base(ch) + 4, 32'hffffffff);
			bus(0, base(ch) + 4, 0);
			chk(32'h1f, rd_q);
			bus(1, base(ch), 32'hfffffffb);
			bus(0, base(ch), 0);
			chk({16'h0, link10_pin[ch], 15'h10db}, rd_q);
			// Upper lane alone: only the gate bit in byte one may change
			avs_byteenable <= 4'h2;
			bus(1, base(ch), 32'h0);
			avs_byteenable <= 4'hf;
			bus(0, base(ch), 0);
			chk({16'h0, link10_pin[ch], 15'h00db}, rd_q);
			bus(1, base(ch), 32'h4);
			repeat (8) @(posedge mclk);
			bus(0, base(ch), 0);
			chk({16'h0, link10_pin[ch], 15'h0}, rd_q);
			bus(0, base(ch) + 4, 0);
			chk(32'h0, rd_q);
		end
		// Link pin moves; both status bits must follow after the buffer flop
		link10_pin <= 2'h2;
		repeat (2) @(posedge mclk);
		bus(0, base(0), 0);
		chk(32'h0, rd_q);
		bus(0, base(1), 0);
		chk(32'h8000, rd_q);
		bus(0, 32'hf00e0000, 0);
		chk(32'h0, rd_q);
	endtask
	task automatic s_ctrl();
		for (int ch = 0; ch < 2; ch++) begin
			for (int v = 1; v >= 0; v--) begin
				bus(1, base(ch), v ? 32'hd0 : 32'h0);
				repeat (2) @(posedge mclk);
				chk({v[0], !v[0]}, {wrap_on[ch], tx_pins_en[ch]});
				chk(v, endec_sel[ch]);
				chk(v, endec_loop_signal[ch]);
			end
		end
	endtask
	task automatic s_duplex();
		frame(0, AD[0], 1'b0);
		for (int i = 0; i < 3; i++) begin
			bus(1, base(0), i == 0 ? 32'h0 : (i == 1 ? 32'h8 : 32'h10));
			repeat (2) @(posedge mclk);
			chk(i != 0, tx_start_ok[0]);
		end
		bus(1, base(0), 0);
		repeat (14) @(posedge mclk);
		chk(1, tx_start_ok[0]);
	endtask
	task automatic s_halt();
		frame(0, AD[0], 1'b0);
		// Transmit busy too: neither direction may stop mid-frame
		tx_busy[0] <= 1'b1;
		bus(1, base(0), 32'h1);
		repeat (2) @(posedge mclk);
		chk(2'b11, {tx_run[0], rx_run[0]});
		tx_busy[0] <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(2'b01, {tx_run[0], rx_run[0]});
		repeat (25) @(posedge mclk);
		chk(0, rx_run[0]);
		bus(1, base(0), 0);
		frame(0, AD[0], 1'b0);
		bus(1, base(0), 32'h2);
		repeat (2) @(posedge mclk);
		chk(2'b00, {tx_run[0], rx_run[0]});
		bus(1, base(0), 0);
		repeat (25) @(posedge mclk);
	endtask
	task automatic s_mdc();
		int n;
		logic p;
		n = 0;
		p = mdc[0];
		repeat (200) begin
			@(posedge mclk);
			if (mdc[0] !== p) n++;
			p = mdc[0];
		end
		chk(8, n);
		bus(1, base(0), 32'h1000);
		repeat (2) @(posedge mclk);
		n = 0;
		repeat (100) begin
			@(posedge mclk);
			if (mdc[0] !== 1'b0) n++;
		end
		chk(0, n);
		bus(1, base(0), 0);
	endtask
	task automatic s_filt();
		int k;
		for (int ch = 0; ch < 2; ch++) begin
			for (int i = 0; i < 12; i++) begin
				bus(1, base(ch) + 4, {27'h0, T[i][8:4]});
				frame(ch, AD[T[i][1:0]], T[i][3]);
				k = 0;
				while (rx_accept_valid[ch] !== 1'b1 && k < 40) begin
					@(posedge mclk);
					k++;
				end
				chk({1'b1, T[i][2]}, {rx_accept_valid[ch], rx_accept[ch]});
				repeat (24) @(posedge mclk);
			end
		end
	endtask
	// Reset for three cycles, then each scenario in turn
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		s_regs();
		s_ctrl();
		s_duplex();
		s_halt();
		s_mdc();
		s_filt();
		give_verdict();
	end
endmodule // emf_top_tb
